// ---- verilog/adc_defs.svh ----
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADC_PCM_W 16
`define ADC_CODE_W 4
`define ADC_MAG_W 3
`define ADC_BYTE_W 8
`define ADC_IDX_W 7
`define ADC_STEP_N 88
`define ADC_IDX_MIN 8'sh00
`define ADC_IDX_MAX 8'sh57
`define ADC_IDX_RST 7'h00
`define ADC_PRED_RST 16'sh0000
`define ADC_PCM_MAX 18'sh0_7fff
`define ADC_PCM_MIN 18'sh3_8000
`define ADC_CHG_M7 8'sh08
`define ADC_CHG_M6 8'sh06
`define ADC_CHG_M5 8'sh04
`define ADC_CHG_M4 8'sh02
`define ADC_CHG_LOW 8'shff
`define ADC_PAD_CODE 4'h0
`define ADC_FIFO_W 8
`define ADC_FIFO_DEPTH 16

`endif

// ---- verilog/adc_pkg.sv ----
`include "adc_defs.svh"

package adc_pkg;

  typedef struct packed {
    logic signed [`ADC_PCM_W-1:0] pred;
    logic [`ADC_IDX_W-1:0] idx;
  } adc_track_t;

  typedef enum logic [1:0] {
    ADC_NIB_HI = 2'b01,
    ADC_NIB_LO = 2'b10
  } adc_nib_t;

endpackage : adc_pkg

// ---- verilog/adc_fifo.sv ----
`timescale 1ns/100ps
`include "adc_defs.svh"

module adc_fifo #(
  parameter int W = `ADC_FIFO_W,
  parameter int D = `ADC_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointers wrap by compare so any depth works, not only powers of two
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data_i;
      wr_nxt = (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; valid is governed by the count
  always_ff @(posedge clk_i) begin
    mem_r <= mem_nxt;
  end

endmodule : adc_fifo

// ---- verilog/adc_codec.sv ----
// Operation
// - Each 16-bit sample becomes one 4-bit code and back, four to one.
// - Output is previous output plus or minus step times (b2+b1/2+b0/4+1/8).
// - Magnitude comes from the three low code bits, zero to seven units.
// - Index change: 7 gives +8, 6 +6, 5 +4, 4 +2, else -1.
// - Step size adapts per sample, so equal codes give different changes.
// - Step size comes from a fixed rising table, 5 up to 26565.
// - New step is entry offset by the index change; used next sample.
// - Encoder codes only the offset from its copy of the decoder prediction; a flush pad moves the decoder tracker but not this copy.
// - Two codes share each stored byte; samples packed pairwise.
`timescale 1ns/100ps
`include "adc_defs.svh"

module adc_codec
  import adc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Encoder: PCM in, packed bytes out
  input wire logic [`ADC_PCM_W-1:0] enc_pcm_i,
  input wire logic enc_pcm_valid_i,
  output logic enc_pcm_ready_o,
  input wire logic enc_flush_i,
  output logic [`ADC_BYTE_W-1:0] enc_byte_o,
  output logic enc_byte_valid_o,
  input wire logic enc_byte_ready_i,
  output logic [`ADC_IDX_W-1:0] enc_idx_o,
  // Decoder: packed bytes in, PCM out
  input wire logic [`ADC_BYTE_W-1:0] dec_byte_i,
  input wire logic dec_byte_valid_i,
  output logic dec_byte_ready_o,
  output logic [`ADC_PCM_W-1:0] dec_pcm_o,
  output logic dec_pcm_valid_o,
  input wire logic dec_pcm_ready_i,
  output logic [`ADC_IDX_W-1:0] dec_idx_o
);

  // Step sizes, strictly rising
  localparam logic [15:0] STEP_TAB [`ADC_STEP_N] = '{
    5, 6, 7, 8, 9, 10, 11, 12, 14, 15,
    17, 18, 20, 22, 25, 27, 30, 33, 37, 40,
    44, 49, 54, 59, 65, 72, 79, 87, 95, 105,
    116, 127, 140, 154, 170, 187, 205, 226, 248, 273,
    301, 331, 364, 400, 440, 485, 533, 586, 645, 710,
    781, 859, 945, 1039, 1143, 1258, 1384, 1522, 1674, 1842,
    2026, 2228, 2451, 2697, 2966, 3263, 3589, 3948, 4343, 4777,
    5255, 5781, 6359, 6995, 7694, 8464, 9310, 10242, 11266, 12392,
    13632, 14995, 16494, 18144, 19958, 21954, 24150, 26565
  };

  function automatic logic signed [7:0] idx_change(
    input logic [`ADC_MAG_W-1:0] mag
  );
    logic signed [7:0] chg;
    unique case (mag)
      3'h7: chg = `ADC_CHG_M7;
      3'h6: chg = `ADC_CHG_M6;
      3'h5: chg = `ADC_CHG_M5;
      3'h4: chg = `ADC_CHG_M4;
      default: chg = `ADC_CHG_LOW;
    endcase
    return chg;
  endfunction : idx_change

  // Shared reconstruction: encoder and decoder run the same update
  function automatic adc_track_t track_advance(
    input adc_track_t s,
    input logic [`ADC_CODE_W-1:0] code
  );
    logic [18:0] prod;
    logic [15:0] delta;
    logic signed [17:0] base;
    logic signed [17:0] sum;
    logic signed [7:0] nidx;
    adc_track_t r;
    // step*(2m+1)/8 equals step*(b2+b1/2+b0/4+1/8)
    prod = 19'(STEP_TAB[s.idx]) * 19'({code[2:0], 1'b1});
    delta = prod[18:3];
    base = 18'(s.pred);
    if (code[3]) begin
      sum = base - $signed({2'b00, delta});
    end else begin
      sum = base + $signed({2'b00, delta});
    end
    if (sum > `ADC_PCM_MAX) begin
      r.pred = 16'(`ADC_PCM_MAX);
    end else if (sum < `ADC_PCM_MIN) begin
      r.pred = 16'(`ADC_PCM_MIN);
    end else begin
      r.pred = sum[15:0];
    end
    // The new index only addresses the step of the next sample
    nidx = $signed({1'b0, s.idx}) + idx_change(code[2:0]);
    if (nidx < `ADC_IDX_MIN) begin
      r.idx = '0;
    end else if (nidx > `ADC_IDX_MAX) begin
      r.idx = 7'(`ADC_IDX_MAX);
    end else begin
      r.idx = nidx[6:0];
    end
    return r;
  endfunction : track_advance

  // Quantise the offset from the shared prediction
  function automatic logic [`ADC_CODE_W-1:0] quantise(
    input adc_track_t s,
    input logic [`ADC_PCM_W-1:0] pcm
  );
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [16:0] step;
    logic [2:0] m;
    diff = 17'($signed(pcm)) - 17'(s.pred);
    mag = diff[16] ? 17'(-diff) : 17'(diff);
    step = 17'(STEP_TAB[s.idx]);
    m = '0;
    if (mag >= step) begin
      m[2] = 1'b1;
      mag = mag - step;
    end
    if (mag >= (step >> 1)) begin
      m[1] = 1'b1;
      mag = mag - (step >> 1);
    end
    if (mag >= (step >> 2)) begin
      m[0] = 1'b1;
    end
    return {diff[16], m};
  endfunction : quantise

  // ---------------- Encoder ----------------
  adc_track_t enc_trk_r, enc_trk_nxt;
  adc_nib_t enc_nib_r, enc_nib_nxt;
  logic [`ADC_CODE_W-1:0] enc_hi_r, enc_hi_nxt;
  logic [`ADC_CODE_W-1:0] enc_code;
  logic [`ADC_BYTE_W-1:0] fifo_in_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic enc_take;

  assign enc_code = quantise(enc_trk_r, enc_pcm_i);
  // Upper nibble always free; lower nibble needs room to push the byte
  assign enc_pcm_ready_o = (enc_nib_r == ADC_NIB_HI) || fifo_in_ready;
  assign enc_take = enc_pcm_valid_i && enc_pcm_ready_o;

  always_comb begin
    enc_trk_nxt = enc_trk_r;
    enc_nib_nxt = enc_nib_r;
    enc_hi_nxt = enc_hi_r;
    fifo_in_valid = 1'b0;
    fifo_in_data = {enc_hi_r, enc_code};
    unique case (enc_nib_r)
      ADC_NIB_HI: begin
        if (enc_take) begin
          enc_hi_nxt = enc_code;
          enc_trk_nxt = track_advance(enc_trk_r, enc_code);
          enc_nib_nxt = ADC_NIB_LO;
        end
      end
      ADC_NIB_LO: begin
        if (enc_pcm_valid_i) begin
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            enc_trk_nxt = track_advance(enc_trk_r, enc_code);
            enc_nib_nxt = ADC_NIB_HI;
          end
        end else if (enc_flush_i) begin
          // Odd tail: pad code is stored but does not move the tracker
          fifo_in_valid = 1'b1;
          fifo_in_data = {enc_hi_r, `ADC_PAD_CODE};
          if (fifo_in_ready) begin
            enc_nib_nxt = ADC_NIB_HI;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enc_trk_r <= '{pred: `ADC_PRED_RST, idx: `ADC_IDX_RST};
      enc_nib_r <= ADC_NIB_HI;
      enc_hi_r <= '0;
    end else begin
      enc_trk_r <= enc_trk_nxt;
      enc_nib_r <= enc_nib_nxt;
      enc_hi_r <= enc_hi_nxt;
    end
  end

  assign enc_idx_o = enc_trk_r.idx;

  // Output buffer lets storage stall without losing samples
  adc_fifo #(
    .W(`ADC_FIFO_W),
    .D(`ADC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(fifo_in_data),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(enc_byte_o),
    .out_valid_o(enc_byte_valid_o),
    .out_ready_i(enc_byte_ready_i)
  );

  // ---------------- Decoder ----------------
  adc_track_t dec_trk_r, dec_trk_nxt;
  adc_nib_t dec_nib_r, dec_nib_nxt;
  logic [`ADC_CODE_W-1:0] dec_lo_r, dec_lo_nxt;
  logic [`ADC_PCM_W-1:0] dec_pcm_r, dec_pcm_nxt;
  logic dec_vld_r, dec_vld_nxt;
  logic dec_room;
  logic [`ADC_CODE_W-1:0] dec_code;
  logic dec_have;

  // Output register free or emptying this cycle
  assign dec_room = !dec_vld_r || dec_pcm_ready_i;
  assign dec_byte_ready_o = (dec_nib_r == ADC_NIB_HI) && dec_room;

  always_comb begin
    dec_trk_nxt = dec_trk_r;
    dec_nib_nxt = dec_nib_r;
    dec_lo_nxt = dec_lo_r;
    dec_pcm_nxt = dec_pcm_r;
    dec_vld_nxt = dec_vld_r && !dec_pcm_ready_i;
    dec_code = dec_lo_r;
    dec_have = 1'b0;
    unique case (dec_nib_r)
      ADC_NIB_HI: begin
        dec_code = dec_byte_i[7:4];
        dec_have = dec_byte_valid_i && dec_room;
        if (dec_have) begin
          dec_lo_nxt = dec_byte_i[3:0];
          dec_nib_nxt = ADC_NIB_LO;
        end
      end
      ADC_NIB_LO: begin
        dec_have = dec_room;
        if (dec_have) begin
          dec_nib_nxt = ADC_NIB_HI;
        end
      end
    endcase
    if (dec_have) begin
      dec_trk_nxt = track_advance(dec_trk_r, dec_code);
      dec_pcm_nxt = dec_trk_nxt.pred;
      dec_vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_trk_r <= '{pred: `ADC_PRED_RST, idx: `ADC_IDX_RST};
      dec_nib_r <= ADC_NIB_HI;
      dec_lo_r <= '0;
      dec_pcm_r <= `ADC_PRED_RST;
      dec_vld_r <= 1'b0;
    end else begin
      dec_trk_r <= dec_trk_nxt;
      dec_nib_r <= dec_nib_nxt;
      dec_lo_r <= dec_lo_nxt;
      dec_pcm_r <= dec_pcm_nxt;
      dec_vld_r <= dec_vld_nxt;
    end
  end

  assign dec_pcm_o = dec_pcm_r;
  assign dec_pcm_valid_o = dec_vld_r;
  assign dec_idx_o = dec_trk_r.idx;

endmodule : adc_codec

// ---- sim/adc_codec_checker.sv ----
`timescale 1ns/100ps
module adc_codec_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enc_pcm_valid_i,
  input wire logic enc_pcm_ready_o,
  input wire logic enc_flush_i,
  input wire logic [7:0] enc_byte_o,
  input wire logic enc_byte_valid_o,
  input wire logic enc_byte_ready_i,
  input wire logic [6:0] enc_idx_o,
  input wire logic dec_byte_valid_i,
  input wire logic dec_byte_ready_o,
  input wire logic [15:0] dec_pcm_o,
  input wire logic dec_pcm_valid_o,
  input wire logic dec_pcm_ready_i,
  input wire logic [6:0] dec_idx_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ph_r;
  logic ph_nxt;
  // Nibble phase of the encoder, rebuilt from the handshakes and the flush input
  always_comb begin
    ph_nxt = ph_r;
    if (enc_pcm_valid_i && enc_pcm_ready_o) ph_nxt = !ph_r;
    // A flush only closes the byte when the buffer has room to take it
    else if (ph_r && enc_flush_i && !enc_pcm_valid_i && enc_pcm_ready_o)
      ph_nxt = 1'b0;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ph_r <= 1'b0;
    else ph_r <= ph_nxt;
  end
  property p_pair;
    ph_r && enc_pcm_valid_i && enc_pcm_ready_o |=> enc_byte_valid_o;
  endproperty
  a_pair: assert property (p_pair) else $error("no byte");
  property p_rdy;
    !ph_r |-> enc_pcm_ready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_bhold;
    enc_byte_valid_o && !enc_byte_ready_i |=>
      enc_byte_valid_o && $stable(enc_byte_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("byte lost");
  property p_lim;
    enc_idx_o <= 7'h57 && dec_idx_o <= 7'h57;
  endproperty
  a_lim: assert property (p_lim) else $error("index range");
  property p_step;
    enc_idx_o != $past(enc_idx_o) |-> enc_idx_o == 7'h57 ||
      7'(enc_idx_o - $past(enc_idx_o)) inside
      {7'h08, 7'h06, 7'h04, 7'h02, 7'h7f};
  endproperty
  a_step: assert property (p_step) else $error("index step");
  property p_cause;
    $changed(enc_idx_o) |-> $past(enc_pcm_valid_i) && $past(enc_pcm_ready_o);
  endproperty
  a_cause: assert property (p_cause) else $error("index moved");
  property p_dtake;
    dec_byte_valid_i && dec_byte_ready_o |=>
      dec_pcm_valid_o && !dec_byte_ready_o;
  endproperty
  a_dtake: assert property (p_dtake) else $error("no sample");
  property p_dhold;
    dec_pcm_valid_o && !dec_pcm_ready_i |=>
      dec_pcm_valid_o && $stable(dec_pcm_o);
  endproperty
  a_dhold: assert property (p_dhold) else $error("sample lost");
endmodule : adc_codec_checker

// ---- sim/adc_store.sv ----
`timescale 1ns/100ps
module adc_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] in_byte_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [7:0] out_byte_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic stall_i
);
  logic [7:0] q[$];
  logic v;
  // Idle data line toggles so a stale byte is never mistaken for a new one
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.delete();
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_byte_o <= 8'h00;
    end else begin
      if (in_valid_i && in_ready_o) q.push_back(in_byte_i);
      v = out_valid_o && !out_ready_i;
      if (!v && q.size() > 0 && !stall_i) begin
        out_byte_o <= q.pop_front();
        v = 1'b1;
      end else if (!v) out_byte_o <= ~out_byte_o;
      out_valid_o <= v;
      in_ready_o <= !stall_i;
    end
  end
endmodule : adc_store

// ---- sim/tb_adc_codec.sv ----
`timescale 1ns/100ps
module tb_adc_codec;
  logic clk_i = 0, rst_i = 1, enc_pcm_valid_i = 0, enc_flush_i = 0;
  logic dec_pcm_ready_i = 0, stall = 1, hold = 0, st_rdy, sv;
  logic enc_pcm_ready_o, enc_byte_valid_o, dec_byte_ready_o;
  logic dec_pcm_valid_o;
  logic [15:0] enc_pcm_i = 16'h0000, dec_pcm_o;
  logic [7:0] enc_byte_o, sb;
  logic [6:0] enc_idx_o, dec_idx_o;
  int tab[88] = '{5, 6, 7, 8, 9, 10, 11, 12, 14, 15,
    17, 18, 20, 22, 25, 27, 30, 33, 37, 40, 44, 49, 54, 59, 65, 72, 79,
    87, 95, 105, 116, 127, 140, 154, 170, 187, 205, 226, 248, 273, 301,
    331, 364, 400, 440, 485, 533, 586, 645, 710, 781, 859, 945, 1039,
    1143, 1258, 1384, 1522, 1674, 1842, 2026, 2228, 2451, 2697, 2966,
    3263, 3589, 3948, 4343, 4777, 5255, 5781, 6359, 6995, 7694, 8464,
    9310, 10242, 11266, 12392, 13632, 14995, 16494, 18144, 19958, 21954,
    24150, 26565};
  int ep, ei, dp, di, hi, cyc, mismatches, compares;
  bit ph;
  int eb[$], pq[$];
  adc_codec dut_u (.clk_i, .rst_i, .enc_pcm_i, .enc_pcm_valid_i,
    .enc_pcm_ready_o, .enc_flush_i, .enc_byte_o, .enc_byte_valid_o,
    .enc_byte_ready_i(st_rdy), .enc_idx_o, .dec_byte_i(sb),
    .dec_byte_valid_i(sv), .dec_byte_ready_o, .dec_pcm_o,
    .dec_pcm_valid_o, .dec_pcm_ready_i, .dec_idx_o);
  adc_store st_u (.clk_i, .rst_i, .in_byte_i(enc_byte_o),
    .in_valid_i(enc_byte_valid_o), .in_ready_o(st_rdy), .out_byte_o(sb),
    .out_valid_o(sv), .out_ready_i(dec_byte_ready_o), .stall_i(stall));
  initial forever #10 clk_i = ~clk_i;
  function automatic void upd(int c, ref int p, ref int x);
    int m, d;
    m = c % 8;
    d = (tab[x] * (2 * m + 1)) / 8;
    p = c >= 8 ? p - d : p + d;
    p = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
    x += m == 7 ? 8 : m == 6 ? 6 : m == 5 ? 4 : m == 4 ? 2 : -1;
    x = x > 87 ? 87 : (x < 0 ? 0 : x);
  endfunction : upd
  function automatic int enc(int s);
    int a, st, c;
    st = tab[ei];
    c = s < ep ? 8 : 0;
    a = s < ep ? ep - s : s - ep;
    if (a >= st) begin
      c += 4;
      a -= st;
    end
    if (a >= st / 2) begin
      c += 2;
      a -= st / 2;
    end
    if (a >= st / 4) c += 1;
    upd(c, ep, ei);
    return c;
  endfunction : enc
  function automatic void pair(int l);
    eb.push_back(hi * 16 + l);
    upd(hi, dp, di);
    pq.push_back(dp);
    upd(l, dp, di);
    pq.push_back(dp);
  endfunction : pair
  function automatic logic [15:0] gen(int m);
    if (m == 1) return 16'($urandom % 8);
    if (m == 2) return $urandom % 2 ? 16'h7fff : 16'h8000;
    return 16'($urandom);
  endfunction : gen
  task automatic chk(string n, int e, logic [15:0] g);
    compares++;
    if (g !== 16'(e)) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, 16'(e), g);
    end
  endtask : chk
  task automatic send(logic [15:0] s);
    enc_pcm_i = s;
    enc_pcm_valid_i = 1'b1;
    while (enc_pcm_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    if (ph) pair(enc(int'($signed(s))));
    else hi = enc(int'($signed(s)));
    ph = !ph;
  endtask : send
  task automatic fin(string n);
    enc_pcm_valid_i = 1'b0;
    while (pq.size() > 0 || eb.size() > 0) @(negedge clk_i);
    chk("enc_idx", ei, {9'h000, enc_idx_o});
    chk("dec_idx", di, {9'h000, dec_idx_o});
    $display("test %s done", n);
  endtask : fin
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(negedge clk_i) begin
    dec_pcm_ready_i <= $urandom % 3 != 0;
    stall <= hold || $urandom % 4 == 0;
  end
  always @(posedge clk_i) if (!rst_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
    if (enc_byte_valid_o && st_rdy)
      chk("enc_byte", eb.pop_front(), {8'h00, enc_byte_o});
    if (dec_pcm_valid_o && dec_pcm_ready_i)
      chk("dec_pcm", pq.pop_front(), dec_pcm_o);
  end
  initial begin
    void'($urandom(32'h0013));
    repeat (8) @(negedge clk_i);
    rst_i = 0;
    for (int m = 0; m < 3; m++) begin
      repeat (100) send(gen(m));
      fin("stream");
    end
    send(16'h1234);
    enc_pcm_valid_i = 1'b0;
    enc_flush_i = 1'b1;
    @(negedge clk_i);
    enc_flush_i = 1'b0;
    pair(0);
    ph = 0;
    fin("flush");
    hold = 1;
    repeat (3) @(negedge clk_i);
    repeat (33) send(gen(0));
    enc_pcm_valid_i = 1'b0;
    @(negedge clk_i);
    chk("enc_ready", 0, {15'h0000, enc_pcm_ready_o});
    hold = 0;
    send(gen(0));
    fin("fill");
    repeat (3) send(gen(0));
    enc_pcm_valid_i = 1'b0;
    rst_i = 1;
    repeat (2) @(negedge clk_i);
    chk("idx_rst", 0, {9'h000, dec_idx_o});
    rst_i = 0;
    {ep, ei, dp, di, ph} = 0;
    eb.delete();
    pq.delete();
    repeat (20) send(gen(0));
    fin("reset");
    end_of_test();
  end
endmodule : tb_adc_codec
bind adc_codec adc_codec_checker chk_u (.*);
